// [rtl/percr_pkg.sv]
package percr_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] PERCR_OFS_EVENT_SELECT = 8'h00;
  localparam logic [7:0] PERCR_OFS_MODES        = 8'h04;
  localparam logic [7:0] PERCR_OFS_CHECK        = 8'h08;
  localparam logic [7:0] PERCR_OFS_TB_LOWER     = 8'h0c;
  localparam logic [7:0] PERCR_OFS_TB_UPPER     = 8'h10;
  localparam logic [7:0] PERCR_OFS_CHECK_STATUS = 8'h14;

  // event_select fields
  localparam int PERCR_EV_CODE_LSB = 0;
  localparam int PERCR_EV_CODE_W   = 5;
  localparam int PERCR_EV_SET_BIT  = 8;

  // decode_dispatch_modes fields
  localparam int PERCR_MD_BRANCH_PREDICT = 0;
  localparam int PERCR_MD_TB_HALT        = 1;
  localparam int PERCR_MD_DIAG_ACCESS    = 2;
  localparam int PERCR_MD_PIPE_OVERLAP   = 3;
  localparam int PERCR_MD_MULTI_ISSUE    = 4;

  // machine_check_enables fields
  localparam int PERCR_CK_WARM      = 0;
  localparam int PERCR_CK_OVER      = 1;
  localparam int PERCR_CK_RESET_TYP = 2;
  localparam int PERCR_CK_FETCH_EN  = 3;
  localparam int PERCR_CK_L2_EN     = 5;
  localparam int PERCR_CK_BUS_EN    = 6;
  localparam int PERCR_CK_PAR_EN    = 7;
  localparam int PERCR_CK_XLAT_EN   = 8;
  localparam int PERCR_CK_SOFT      = 9;
  localparam logic [31:0] PERCR_CK_WMASK = 32'h0000_03f8;

  // event codes
  localparam logic [4:0] PERCR_EV_TIMEBASE = 5'h00;
  localparam logic [4:0] PERCR_EV_FREEZE   = 5'h01;
  localparam logic [4:0] PERCR_EV_ICACHE   = 5'h04;
  localparam logic [4:0] PERCR_EV_ITLB     = 5'h05;
  localparam logic [4:0] PERCR_EV_DCACHE   = 5'h08;
  localparam logic [4:0] PERCR_EV_TLB      = 5'h09;
  localparam logic [4:0] PERCR_EV_L2       = 5'h0a;
  localparam logic [4:0] PERCR_EV_SNOOP    = 5'h0b;
  localparam logic [4:0] PERCR_EV_BR_TAKEN = 5'h18;
  localparam logic [4:0] PERCR_EV_BR_NOT   = 5'h19;

  // reset values
  localparam logic [31:0] PERCR_RST_EVENT = 32'h0000_0000;
  localparam logic [31:0] PERCR_RST_MODES = 32'h0000_0000;
  localparam logic [31:0] PERCR_RST_CHECK = 32'h0000_0000;

  // timing: one bus cycle is 4 aclk cycles; time base ticks every 4 bus cycles
  localparam int PERCR_CLK_NS        = 10;
  localparam int PERCR_BUS_CYCLE_NS  = 40;
  localparam int PERCR_BUS_DIV       = PERCR_BUS_CYCLE_NS / PERCR_CLK_NS;
  localparam int PERCR_TB_BUS_CYCLES = 4;

  localparam logic [1:0] PERCR_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PERCR_RESP_SLVERR = 2'b10;
endpackage

// [rtl/percr_regs.sv]
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - selector zero chains both words into a 64-bit counter, tick every four bus cycles.
// - nonzero selector stops time base keeping; words count other things.
// - selector one freezes both words.
// - selector above one: upper counts completed instructions, lower counts chosen event.
// - codes 4,5,8,9,10,11 count cache, TLB, L2, snoop accesses or misses.
// - codes 24,25 count taken or not-taken branches, correct or wrong by set bit.
// - each word wraps from all ones to zero.
// - halt bit matters only when selector is zero.
// - halt set stops the time base; clear lets it tick every fourth bus clock.
// - prediction off treats all branches as not taken.
// - diagnostic access off makes diagnostic load/store illegal.
// - overlap off issues only into an empty pipeline.
// - multi-issue off limits issue to one per cycle, else up to three.
// - enabled or unmaskable check condition raises a machine check.
// - trap enable set vectors to trap; clear enters checkstop.
// - warm and over-temperature flags are reported.
// - reset type flag is one after hard reset, zero after soft; read only.
// - fetch multi-hit enable reports instruction BAT/TLB multi-hits.
// - enables report L2 tag state and bus controller state errors.
// - parity enable reports bus parity; transfer error and check inputs always report.
// - translation multi-hit enable reports TLB or data BAT multi-hits.
// - soft trigger rising from zero to one raises exactly one check.
module percr_regs
  import percr_pkg::*;
#(
  parameter int EVENT_W = 5
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        hard_reset_in,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        instr_done,
  input  wire logic        ev_icache_acc,
  input  wire logic        ev_icache_miss,
  input  wire logic        ev_itlb_acc,
  input  wire logic        ev_itlb_miss,
  input  wire logic        ev_dcache_acc,
  input  wire logic        ev_dcache_miss,
  input  wire logic        ev_tlb_acc,
  input  wire logic        ev_tlb_miss,
  input  wire logic        ev_l2_acc,
  input  wire logic        ev_l2_miss,
  input  wire logic        ev_snoop_acc,
  input  wire logic        ev_snoop_miss,
  input  wire logic        ev_br_taken_ok,
  input  wire logic        ev_br_taken_bad,
  input  wire logic        ev_br_not_ok,
  input  wire logic        ev_br_not_bad,
  input  wire logic        warm_temp_in,
  input  wire logic        over_temp_in,
  input  wire logic        fetch_multi_hit,
  input  wire logic        l2_tag_bad,
  input  wire logic        bus_ctrl_bad,
  input  wire logic        bus_parity_err,
  input  wire logic        xlat_multi_hit,
  input  wire logic        transfer_error_in,
  input  wire logic        machine_check_in,
  input  wire logic        check_trap_enable,
  output logic             branch_predict_on,
  output logic             diag_access_on,
  output logic             pipe_overlap_on,
  output logic             multi_issue_on,
  output logic             machine_check_trap,
  output logic             checkstop
);
  logic [31:0]        event_select;
  logic [31:0]        decode_dispatch_modes;
  logic [31:0]        machine_check_enables;
  logic [31:0]        time_base_lower_word;
  logic [31:0]        time_base_upper_word;
  logic               reset_type;
  logic               soft_prev;
  logic               tb_tick;
  logic               lower_event;
  logic               check_cond;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic [31:0]        next_wr;
  logic [31:0]        rd_mux;
  logic               rd_hit;
  logic               do_write;
  logic               wr_hit;
  logic               wr_event;
  logic               wr_modes;
  logic               wr_check;
  logic               wr_tbl;
  logic               wr_tbu;
  logic [EVENT_W-1:0] ev_code;
  logic               ev_set;
  logic               mode_halt;

  assign ev_code   = event_select[PERCR_EV_CODE_LSB +: EVENT_W];
  assign ev_set    = event_select[PERCR_EV_SET_BIT];
  assign mode_halt = decode_dispatch_modes[PERCR_MD_TB_HALT];

  // divider: 4 aclk per bus cycle, 4 bus cycles per tick
  percr_tick_div #(
    .DIV (PERCR_BUS_DIV * PERCR_TB_BUS_CYCLES)
  ) u_tb_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (1'b1),
    .tick    (tb_tick)
  );

  // write channel capture; address and data may arrive in either order
  assign do_write = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= PERCR_RESP_OKAY;
    end
    else
    begin
      awready <= !aw_held && !awready && !bvalid;
      wready  <= !w_held && !wready && !bvalid;
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr[7:0];
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? PERCR_RESP_OKAY : PERCR_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    wr_event = do_write && aw_addr == PERCR_OFS_EVENT_SELECT;
    wr_modes = do_write && aw_addr == PERCR_OFS_MODES;
    wr_check = do_write && aw_addr == PERCR_OFS_CHECK;
    wr_tbl   = do_write && aw_addr == PERCR_OFS_TB_LOWER;
    wr_tbu   = do_write && aw_addr == PERCR_OFS_TB_UPPER;
    wr_hit   = wr_event || wr_modes || wr_check || wr_tbl || wr_tbu
               || (aw_addr == PERCR_OFS_CHECK_STATUS);
  end

  // byte-lane merge against the addressed register
  always_comb
  begin
    next_wr = rd_mux_of(aw_addr);
    for (int i = 0; i < 4; i++)
      if (w_strb[i])
        next_wr[8*i +: 8] = w_data[8*i +: 8];
  end

  function automatic logic [31:0] rd_mux_of(input logic [7:0] a);
    case (a)
      PERCR_OFS_EVENT_SELECT: rd_mux_of = event_select;
      PERCR_OFS_MODES:        rd_mux_of = decode_dispatch_modes;
      PERCR_OFS_CHECK:        rd_mux_of = machine_check_enables;
      PERCR_OFS_TB_LOWER:     rd_mux_of = time_base_lower_word;
      PERCR_OFS_TB_UPPER:     rd_mux_of = time_base_upper_word;
      PERCR_OFS_CHECK_STATUS: rd_mux_of = {30'h0000_0000, checkstop, machine_check_trap};
      default:                rd_mux_of = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_select          <= PERCR_RST_EVENT;
      decode_dispatch_modes <= PERCR_RST_MODES;
    end
    else
    begin
      if (wr_event)
        event_select <= next_wr & 32'h0000_011f;
      if (wr_modes)
        decode_dispatch_modes <= next_wr & 32'h0000_001f;
    end
  end

  // mode bits drive the issue logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      branch_predict_on <= 1'b0;
      diag_access_on    <= 1'b0;
      pipe_overlap_on   <= 1'b0;
      multi_issue_on    <= 1'b0;
    end
    else
    begin
      branch_predict_on <= decode_dispatch_modes[PERCR_MD_BRANCH_PREDICT];
      diag_access_on    <= decode_dispatch_modes[PERCR_MD_DIAG_ACCESS];
      pipe_overlap_on   <= decode_dispatch_modes[PERCR_MD_PIPE_OVERLAP];
      multi_issue_on    <= decode_dispatch_modes[PERCR_MD_MULTI_ISSUE];
    end
  end

  always_comb
  begin
    case (5'(ev_code))
      PERCR_EV_ICACHE:   lower_event = ev_set ? ev_icache_acc : ev_icache_miss;
      PERCR_EV_ITLB:     lower_event = ev_set ? ev_itlb_acc : ev_itlb_miss;
      PERCR_EV_DCACHE:   lower_event = ev_set ? ev_dcache_acc : ev_dcache_miss;
      PERCR_EV_TLB:      lower_event = ev_set ? ev_tlb_acc : ev_tlb_miss;
      PERCR_EV_L2:       lower_event = ev_set ? ev_l2_acc : ev_l2_miss;
      PERCR_EV_SNOOP:    lower_event = ev_set ? ev_snoop_acc : ev_snoop_miss;
      PERCR_EV_BR_TAKEN: lower_event = ev_set ? ev_br_taken_ok : ev_br_taken_bad;
      PERCR_EV_BR_NOT:   lower_event = ev_set ? ev_br_not_ok : ev_br_not_bad;
      default:           lower_event = 1'b0;
    endcase
  end

  // software writes to a word win over counting in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      time_base_lower_word <= 32'h0000_0000;
      time_base_upper_word <= 32'h0000_0000;
    end
    else if (5'(ev_code) == PERCR_EV_TIMEBASE)
    begin
      // chained time base, halt honoured only here
      if (wr_tbl)
        time_base_lower_word <= next_wr;
      else if (tb_tick && !mode_halt)
        time_base_lower_word <= time_base_lower_word + 32'h0000_0001;
      if (wr_tbu)
        time_base_upper_word <= next_wr;
      else if (tb_tick && !mode_halt && time_base_lower_word == 32'hffff_ffff)
        time_base_upper_word <= time_base_upper_word + 32'h0000_0001;
    end
    else
    begin
      if (wr_tbl)
        time_base_lower_word <= next_wr;
      // independent counters, freeze at one, wrap
      else if (5'(ev_code) != PERCR_EV_FREEZE && lower_event)
        time_base_lower_word <= time_base_lower_word + 32'h0000_0001;
      if (wr_tbu)
        time_base_upper_word <= next_wr;
      else if (5'(ev_code) != PERCR_EV_FREEZE && instr_done)
        time_base_upper_word <= time_base_upper_word + 32'h0000_0001;
    end
  end

  // reset type captured at release from the strap input, read only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      machine_check_enables <= PERCR_RST_CHECK;
      reset_type            <= 1'b0;
      soft_prev             <= 1'b0;
    end
    else
    begin
      if (wr_check)
        machine_check_enables <= (next_wr & PERCR_CK_WMASK) | (machine_check_enables & ~PERCR_CK_WMASK);
      machine_check_enables[PERCR_CK_WARM] <= warm_temp_in;
      machine_check_enables[PERCR_CK_OVER] <= over_temp_in;
      machine_check_enables[PERCR_CK_RESET_TYP] <= reset_type;
      reset_type <= reset_type | hard_reset_in;
      if (hard_reset_in)
        reset_type <= 1'b1;
      soft_prev <= machine_check_enables[PERCR_CK_SOFT];
    end
  end

  always_comb
  begin
    check_cond = transfer_error_in || machine_check_in
      || (fetch_multi_hit && machine_check_enables[PERCR_CK_FETCH_EN])
      || ((l2_tag_bad) && machine_check_enables[PERCR_CK_L2_EN])
      || (bus_ctrl_bad && machine_check_enables[PERCR_CK_BUS_EN])
      || (bus_parity_err && machine_check_enables[PERCR_CK_PAR_EN])
      || (xlat_multi_hit && machine_check_enables[PERCR_CK_XLAT_EN])
      || (machine_check_enables[PERCR_CK_SOFT] && !soft_prev);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      machine_check_trap <= 1'b0;
      checkstop          <= 1'b0;
    end
    else
    begin
      machine_check_trap <= check_cond && check_trap_enable && !checkstop;
      if (check_cond && !check_trap_enable)
        checkstop <= 1'b1;
    end
  end

  // read channel: one outstanding read, answer one cycle after the address is taken
  assign rd_hit = (araddr[7:0] <= PERCR_OFS_CHECK_STATUS) && (araddr[1:0] == 2'b00)
                  && (araddr[31:8] == 24'h000000);
  assign rd_mux = rd_mux_of(araddr[7:0]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= PERCR_RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid && !arready && arvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_hit ? rd_mux : 32'h0000_0000;
        rresp  <= rd_hit ? PERCR_RESP_OKAY : PERCR_RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
endmodule // percr_regs

// [rtl/percr_tick_div.sv]
`timescale 1ns/1ps
// one-cycle enable every DIV cycles of aclk
module percr_tick_div #(
  parameter int DIV = 4
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  output logic      tick
);
  logic [15:0] count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end
    else if (count == 16'(DIV - 1))
    begin
      count <= 16'h0000;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule // percr_tick_div

// [verif/percr_regs_asserts.sv]
`timescale 1ns/1ps
module percr_regs_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bvalid,
  input wire logic check_trap_enable,
  input wire logic machine_check_in,
  input wire logic transfer_error_in,
  input wire logic branch_predict_on,
  input wire logic diag_access_on,
  input wire logic pipe_overlap_on,
  input wire logic multi_issue_on,
  input wire logic machine_check_trap,
  input wire logic checkstop
);
  logic [3:0] b_hist;
  // mode outputs may only move within a few cycles of a write response
  always_ff @(posedge aclk)
    if (!aresetn)
      b_hist <= 4'h0;
    else
      b_hist <= {b_hist[2:0], bvalid};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_fatal_check;
    (transfer_error_in || machine_check_in) && !check_trap_enable;
  endsequence
  sequence s_trapped_check;
    (transfer_error_in || machine_check_in) && check_trap_enable;
  endsequence
  a_predict_src: assert property ($changed(branch_predict_on) |-> |b_hist)
    else $error("predict output moved without a write");
  a_diag_src: assert property ($changed(diag_access_on) |-> |b_hist)
    else $error("diag output moved without a write");
  a_overlap_src: assert property ($changed(pipe_overlap_on) |-> |b_hist)
    else $error("overlap output moved without a write");
  a_issue_src: assert property ($changed(multi_issue_on) |-> |b_hist)
    else $error("multi issue output moved without a write");
  a_trap_gated: assert property (machine_check_trap |-> $past(check_trap_enable))
    else $error("trap pulse while trap disabled");
  a_stop_cause: assert property ($rose(checkstop) |-> !$past(check_trap_enable))
    else $error("checkstop while trap enabled");
  a_stop_sticky: assert property (checkstop |=> checkstop)
    else $error("checkstop dropped");
  a_fatal_stop: assert property (s_fatal_check |=> checkstop)
    else $error("unmaskable check did not stop");
  a_unmasked_trap: assert property (s_trapped_check |=> machine_check_trap)
    else $error("unmaskable check gave no trap");
endmodule // percr_regs_asserts

bind percr_regs percr_regs_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .check_trap_enable(check_trap_enable),
  .machine_check_in(machine_check_in), .transfer_error_in(transfer_error_in),
  .branch_predict_on(branch_predict_on), .diag_access_on(diag_access_on), .pipe_overlap_on(pipe_overlap_on),
  .multi_issue_on(multi_issue_on), .machine_check_trap(machine_check_trap), .checkstop(checkstop)
);

// [verif/percr_regs_tb_top.sv]
`timescale 1ns/1ps
module percr_regs_tb_top;
  import percr_pkg::*;
  logic        aclk, aresetn, hard_rst, trap_en, warm, over, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, bp_on, dg_on, po_on, mi_on, trap, cstop;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0]  wstrb;
  logic [23:0] stim;
  logic [1:0]  bresp, rresp, rsp;
  int          err_total, n_checks, trap_cnt, i;
  int          codes [8] = '{4, 5, 8, 9, 10, 11, 24, 25};
  int          en_pos [5] = '{3, 5, 6, 7, 8};

  percr_regs DUT (
    .aclk(aclk), .aresetn(aresetn), .hard_reset_in(hard_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .instr_done(stim[16]),
    .ev_icache_acc(stim[0]), .ev_icache_miss(stim[1]), .ev_itlb_acc(stim[2]), .ev_itlb_miss(stim[3]),
    .ev_dcache_acc(stim[4]), .ev_dcache_miss(stim[5]), .ev_tlb_acc(stim[6]), .ev_tlb_miss(stim[7]),
    .ev_l2_acc(stim[8]), .ev_l2_miss(stim[9]), .ev_snoop_acc(stim[10]), .ev_snoop_miss(stim[11]),
    .ev_br_taken_ok(stim[12]), .ev_br_taken_bad(stim[13]), .ev_br_not_ok(stim[14]), .ev_br_not_bad(stim[15]),
    .warm_temp_in(warm), .over_temp_in(over), .fetch_multi_hit(stim[17]), .l2_tag_bad(stim[18]),
    .bus_ctrl_bad(stim[19]), .bus_parity_err(stim[20]), .xlat_multi_hit(stim[21]),
    .transfer_error_in(stim[22]), .machine_check_in(stim[23]), .check_trap_enable(trap_en),
    .branch_predict_on(bp_on), .diag_access_on(dg_on), .pipe_overlap_on(po_on), .multi_issue_on(mi_on),
    .machine_check_trap(trap), .checkstop(cstop)
  );

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always_ff @(posedge aclk) if (trap === 1'b1) trap_cnt <= trap_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 200)
    begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic do_reset(input logic hard);
    @(posedge aclk);
    aresetn <= 1'b0;
    hard_rst <= hard;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    hard_rst <= 1'b0;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 200 && !(aw_ok && w_ok); i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) aw_ok = 1'b1;
      if (wready === 1'b1) w_ok = 1'b1;
      awvalid <= ~aw_ok;
      wvalid <= ~w_ok;
    end
    bound(i);
    for (i = 0; i < 200 && bvalid !== 1'b1; i++) @(posedge aclk);
    bound(i);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 200 && arready !== 1'b1; i++) @(posedge aclk);
    bound(i);
    arvalid <= 1'b0;
    for (i = 0; i < 200 && rvalid !== 1'b1; i++) @(posedge aclk);
    bound(i);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      stim[idx] <= 1'b1;
      @(posedge aclk);
      stim[idx] <= 1'b0;
    end
  endtask
  task automatic traps_since(input int c, input int e);
    repeat (4) @(posedge aclk);
    check(trap_cnt - c, e);
  endtask

  task automatic t_regs();
    axi_read(PERCR_OFS_EVENT_SELECT);
    check(rd, PERCR_RST_EVENT);
    axi_read(PERCR_OFS_MODES);
    check(rd, PERCR_RST_MODES);
    axi_write(PERCR_OFS_CHECK, 32'hffff_ffff);
    axi_read(PERCR_OFS_CHECK);
    check(rd, PERCR_CK_WMASK);
    axi_write(PERCR_OFS_CHECK, 32'h0);
    axi_write(8'h20, 32'h1);
    check(rsp, PERCR_RESP_SLVERR);
    axi_read(8'h20);
    check({rd[29:0], rsp}, {30'h0, PERCR_RESP_SLVERR});
    $display("t_regs done");
  endtask
  // each mode bit but halt reaches its own output; halt reaches none
  task automatic t_modes();
    for (int j = 0; j < 5; j++)
    begin
      axi_write(PERCR_OFS_MODES, 32'h1 << j);
      repeat (3) @(posedge aclk);
      check({mi_on, po_on, dg_on, bp_on}, (j == 1) ? 4'h0 : (4'h1 << ((j == 0) ? 0 : j - 1)));
    end
    axi_write(PERCR_OFS_MODES, 32'h0);
    $display("t_modes done");
  endtask
  // time base rate, chaining and wrap
  task automatic t_timebase();
    axi_write(PERCR_OFS_TB_UPPER, 32'h5);
    axi_write(PERCR_OFS_TB_LOWER, 32'hffff_ffff);
    repeat (40) @(posedge aclk);
    axi_read(PERCR_OFS_TB_UPPER);
    check(rd, 32'h6);
    axi_write(PERCR_OFS_TB_LOWER, 32'h0);
    repeat (20 * PERCR_BUS_DIV * PERCR_TB_BUS_CYCLES) @(posedge aclk);
    axi_read(PERCR_OFS_TB_LOWER);
    check(rd inside {32'd20, 32'd21}, 1'b1);
    axi_write(PERCR_OFS_MODES, 32'h2);
    axi_write(PERCR_OFS_TB_LOWER, 32'h100);
    repeat (64) @(posedge aclk);
    axi_read(PERCR_OFS_TB_LOWER);
    check(rd, 32'h100);
    axi_write(PERCR_OFS_EVENT_SELECT, 32'h2);
    axi_write(PERCR_OFS_TB_UPPER, 32'h0);
    pulse(16, 5);
    axi_read(PERCR_OFS_TB_UPPER);
    check(rd, 32'h5);
    axi_read(PERCR_OFS_TB_LOWER);
    check(rd, 32'h100);
    axi_write(PERCR_OFS_EVENT_SELECT, 32'h1);
    pulse(16, 3);
    repeat (40) @(posedge aclk);
    axi_read(PERCR_OFS_TB_UPPER);
    check(rd, 32'h5);
    axi_write(PERCR_OFS_EVENT_SELECT, 32'h2);
    axi_write(PERCR_OFS_TB_UPPER, 32'hffff_ffff);
    pulse(16, 1);
    axi_read(PERCR_OFS_TB_UPPER);
    check(rd, 32'h0);
    axi_write(PERCR_OFS_MODES, 32'h0);
    $display("t_timebase done");
  endtask
  // every event code and set bit
  task automatic t_events();
    for (int p = 0; p < 8; p++)
      for (int s = 0; s < 2; s++)
      begin
        axi_write(PERCR_OFS_EVENT_SELECT, (s << PERCR_EV_SET_BIT) | codes[p]);
        axi_write(PERCR_OFS_TB_LOWER, 32'h0);
        pulse(2 * p + 1 - s, 3);
        pulse(2 * p + s, 2);
        axi_read(PERCR_OFS_TB_LOWER);
        check(rd, 32'h3);
      end
    $display("t_events done");
  endtask
  task automatic t_checks();
    int tc;
    for (int j = 0; j < 5; j++)
    begin
      axi_write(PERCR_OFS_CHECK, 32'h0);
      traps_since(trap_cnt, 0);
      // count taken before the pulse, the trap lands a cycle after it
      tc = trap_cnt;
      pulse(17 + j, 1);
      traps_since(tc, 0);
      axi_write(PERCR_OFS_CHECK, 32'h1 << en_pos[j]);
      tc = trap_cnt;
      pulse(17 + j, 1);
      traps_since(tc, 1);
    end
    axi_write(PERCR_OFS_CHECK, 32'h0);
    tc = trap_cnt;
    pulse(22, 1);
    pulse(23, 1);
    traps_since(tc, 2);
    for (int k = 0; k < 4; k++)
    begin
      tc = trap_cnt;
      axi_write(PERCR_OFS_CHECK, (k == 2) ? 32'h0 : 32'h200);
      traps_since(tc, (k == 1 || k == 2) ? 0 : 1);
    end
    trap_en <= 1'b0;
    pulse(23, 1);
    repeat (3) @(posedge aclk);
    check(cstop, 1'b1);
    axi_read(PERCR_OFS_CHECK_STATUS);
    check(rd & 32'h2, 32'h2);
    $display("t_checks done");
  endtask
  // temperature flags and hard reset type
  task automatic t_hard();
    warm <= 1'b1;
    over <= 1'b1;
    trap_en <= 1'b1;
    do_reset(1'b1);
    check(cstop, 1'b0);
    axi_write(PERCR_OFS_CHECK, 32'h0);
    axi_read(PERCR_OFS_CHECK);
    check(rd & 32'h7, 32'h7);
    $display("t_hard done");
  endtask

  initial
  begin
    {aresetn, hard_rst, warm, over, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, stim} = '0;
    trap_en = 1'b1;
    wstrb = 4'h0;
    do_reset(1'b0);
    t_regs();
    t_modes();
    t_timebase();
    t_events();
    t_checks();
    t_hard();
    complete_run();
  end
endmodule // percr_regs_tb_top
